// File: verilog/uart_fifo_line_control_consts.vh
// Constants for the UART FIFO and line control block
`ifndef UART_FIFO_LINE_CONTROL_CONSTS_VH
`define UART_FIFO_LINE_CONTROL_CONSTS_VH
// Register indexes; byte address is four times the index
`define IDX_DATA 3'h0
`define IDX_DIV_HIGH 3'h1
`define IDX_FIFO 3'h2
`define IDX_FORMAT 3'h3
`define IDX_COND 3'h5
`define ENH_KEY 8'hbf
// Field positions
`define FS_EN 0
`define FS_RXCLR 1
`define FS_TXCLR 2
`define FS_DMA 3
`define LF_STOP 2
`define LF_PEN 3
`define LF_EVEN 4
`define LF_FORCE 5
`define LF_BRK 6
`define LF_DLAB 7
`define EF_ENH 4
// Reset values
`define FORMAT_RST 8'h03
`define DIV_RST 16'h0001
// FIFO geometry
`define FIFO_FULL 7'h40
// Trigger levels
`define TT0 7'h08
`define TT1 7'h10
`define TT2 7'h20
`define TT3 7'h38
`define RT0 7'h08
`define RT1 7'h10
`define RT2 7'h38
`define RT3 7'h3c
// Ticks per bit time of 16 oversampling ticks
`define TK_MID 5'h07
`define TK_BIT 5'h0f
`define TK_STOP15 5'h17
`define TK_STOP2 5'h1f
`endif

// File: verilog/uart_fifo_line_control.v
// One UART channel: FIFOs, shifters, line format and status, APB slave
// Operation
// - Receiver deserialises RX characters into a 64-entry receive buffer.
// - FIFOs off: receive uses entry zero only, new character overwrites.
// - Each receive entry keeps break, framing and parity flags with data.
// - Transmit bytes buffered in 64 entries always, serialised; excess lost.
// - FIFO setup bit 0 enables the receive FIFO; changing it clears both FIFOs.
// - FIFO setup bit 1 clears receive FIFO and counters, self-clearing.
// - FIFO setup bit 2 clears transmit FIFO and counters, self-clearing.
// - Bits 5:4 set transmit trigger: 8, 16, 32, 56 spaces.
// - Bits 7:6 set receive trigger: 8, 16, 56, 60 characters.
// - Transmit trigger field writable only with enhanced functions enabled.
// - Line format bits 1:0 choose five to eight data bits.
// - Bit 2 adds stop bits: 1.5 for five bits, else two.
// - Bit 3 enables parity; bit 4 picks even, else odd.
// - Bit 5 forces parity: 1 when bit 4 clear, 0 when set.
// - Bit 6 holds TX low for break while set.
// - Bit 7 opens the divisor latch at the shared addresses.
// - Condition bit 0 shows receive data; bit 1 shows overrun.
// - Bits 4:2 show head entry flags; only data reads advance.
// - Break detected as full low character, stored as zero; stop checked.
// - Bit 5 transmit buffer empty; bit 6 also shifter empty.
// - Bit 7 set while any flagged character sits in receive FIFO.
// - Divisor bytes reachable only while format bit 7 is set.
// - Enhanced feature bit 4 enables and write-guards enhanced functions.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_fifo_line_control_consts.vh"
module uart_fifo_line_control
(
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [4:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_rx,
  output wire o_tx,
  output wire o_rx_dma_req_n,
  output wire o_tx_dma_req_n
);

////////////////////////////////////////////////////////////////////////////
// Helpers
function [7:0] keep_bits;
  input [7:0] d;
  input [1:0] wl;
  begin
    keep_bits = d & (8'hff >> (2'h3 - wl));
  end
endfunction

function par_bit;
  input [7:0] d;
  input [7:0] fmt;
  begin
    if (fmt[`LF_FORCE])
      par_bit = ~fmt[`LF_EVEN];
    else
      par_bit = ^keep_bits(d, fmt[1:0]) ^ ~fmt[`LF_EVEN];
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Registers and state
reg [7:0] format_q;
reg [7:0] enh_q;
reg [15:0] div_q;
reg fifo_en_q;
reg dma_mode_q;
reg [1:0] tx_trig_q;
reg [1:0] rx_trig_q;
reg ovr_q;
reg [31:0] prdata_q;
reg pready_q;
reg pslverr_q;
reg [15:0] baud_q;
reg tick_q;
reg rx_m_q;
reg rx_s_q;
reg tx_q;
reg rx_req_n_q;
reg tx_req_n_q;
reg [7:0] tx_mem [0:63];
reg [5:0] tx_wr_q;
reg [5:0] tx_rd_q;
reg [6:0] tx_cnt_q;
reg [10:0] rx_mem [0:63];
reg [5:0] rx_wr_q;
reg [5:0] rx_rd_q;
reg [6:0] rx_cnt_q;
reg [6:0] err_cnt_q;
reg [6:0] err_cnt_d;
localparam [4:0] T_IDLE = 5'h01;
localparam [4:0] T_START = 5'h02;
localparam [4:0] T_DATA = 5'h04;
localparam [4:0] T_PAR = 5'h08;
localparam [4:0] T_STOP = 5'h10;
reg [4:0] tst_q;
reg [7:0] tsh_q;
reg tpar_q;
reg [2:0] tbit_q;
reg [4:0] ttk_q;
localparam [5:0] R_IDLE = 6'h01;
localparam [5:0] R_START = 6'h02;
localparam [5:0] R_DATA = 6'h04;
localparam [5:0] R_PAR = 6'h08;
localparam [5:0] R_STOP = 6'h10;
localparam [5:0] R_LOW = 6'h20;
reg [5:0] rst_q;
reg [7:0] rsh_q;
reg rpar_q;
reg [2:0] rbit_q;
reg [4:0] rtk_q;

////////////////////////////////////////////////////////////////////////////
// APB decode
wire [2:0] idx = i_paddr[4:2];
wire dlab = format_q[`LF_DLAB];
wire enh_sel = (format_q == `ENH_KEY);
wire aligned = (i_paddr[1:0] == 2'h0);
wire hit = aligned & ((idx == `IDX_DATA) | (idx == `IDX_DIV_HIGH) |
  (idx == `IDX_FIFO) | (idx == `IDX_FORMAT) | (idx == `IDX_COND));
wire acc = i_psel & i_penable & pready_q;
wire wr = acc & i_pwrite & hit;
wire rd = acc & ~i_pwrite & hit;
wire [7:0] wd = i_pwdata[7:0];
wire wr_data = wr & (idx == `IDX_DATA) & ~dlab;
wire wr_fifo = wr & (idx == `IDX_FIFO) & ~enh_sel;
wire rd_data = rd & (idx == `IDX_DATA) & ~dlab;
wire rd_cond = rd & (idx == `IDX_COND);
wire fifo_toggle = wr_fifo & (wd[`FS_EN] != fifo_en_q);
wire rx_clr = (wr_fifo & wd[`FS_RXCLR]) | fifo_toggle;
wire tx_clr = (wr_fifo & wd[`FS_TXCLR]) | fifo_toggle;

wire tx_empty = (tx_cnt_q == 7'h00);
wire rx_any = (rx_cnt_q != 7'h00);
wire [10:0] head = rx_mem[rx_rd_q];
wire [7:0] cond = {(err_cnt_q != 7'h00),
  tx_empty & (tst_q == T_IDLE), tx_empty,
  rx_any ? head[10:8] : 3'h0,
  ovr_q, rx_any};

reg [7:0] rmux;
always @*
begin
  rmux = 8'h00;
  case (idx)
    `IDX_DATA: rmux = dlab ? div_q[7:0] : head[7:0];
    `IDX_DIV_HIGH: rmux = dlab ? div_q[15:8] : 8'h00;
    `IDX_FIFO: rmux = enh_sel ? enh_q : 8'h00;
    `IDX_FORMAT: rmux = format_q;
    `IDX_COND: rmux = cond;
    default: rmux = 8'h00;
  endcase
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    pready_q <= 1'b0;
    prdata_q <= 32'h0000_0000;
    pslverr_q <= 1'b0;
  end
  else
  begin
    pready_q <= i_psel & ~i_penable;
    pslverr_q <= i_psel & ~i_penable & ~hit;
    if (i_psel & ~i_penable)
      prdata_q <= {24'h000000, hit ? rmux : 8'h00};
  end
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    format_q <= `FORMAT_RST;
    enh_q <= 8'h00;
    div_q <= `DIV_RST;
    fifo_en_q <= 1'b0;
    dma_mode_q <= 1'b0;
    tx_trig_q <= 2'h0;
    rx_trig_q <= 2'h0;
  end
  else if (wr)
  begin
    if (idx == `IDX_FORMAT)
      format_q <= wd;
    if (dlab & (idx == `IDX_DATA))
      div_q[7:0] <= wd;
    if (dlab & (idx == `IDX_DIV_HIGH))
      div_q[15:8] <= wd;
    if (enh_sel & (idx == `IDX_FIFO))
      enh_q <= wd;
    if (wr_fifo)
    begin
      fifo_en_q <= wd[`FS_EN];
      dma_mode_q <= wd[`FS_DMA];
      rx_trig_q <= wd[7:6];
      if (enh_q[`EF_ENH])
        tx_trig_q <= wd[5:4];
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Oversampling tick and RX synchroniser
always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    baud_q <= 16'h0000;
    tick_q <= 1'b0;
    rx_m_q <= 1'b1;
    rx_s_q <= 1'b1;
  end
  else
  begin
    rx_m_q <= i_rx;
    rx_s_q <= rx_m_q;
    tick_q <= 1'b0;
    if (div_q != 16'h0000)
    begin
      if (baud_q >= div_q - 16'h0001)
      begin
        baud_q <= 16'h0000;
        tick_q <= 1'b1;
      end
      else
        baud_q <= baud_q + 16'h0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Transmit FIFO and shifter
wire tx_push = wr_data & (tx_cnt_q != `FIFO_FULL);
wire tx_pop = (tst_q == T_IDLE) & ~tx_empty;
wire stop_long = format_q[`LF_STOP];
wire [4:0] stop_end = ~stop_long ? `TK_BIT :
  (format_q[1:0] == 2'h0) ? `TK_STOP15 : `TK_STOP2;

always @(posedge i_core_clk)
begin
  if (tx_push)
    tx_mem[tx_wr_q] <= wd;
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    tx_wr_q <= 6'h00;
    tx_rd_q <= 6'h00;
    tx_cnt_q <= 7'h00;
  end
  else if (tx_clr)
  begin
    tx_wr_q <= 6'h00;
    tx_rd_q <= 6'h00;
    tx_cnt_q <= 7'h00;
  end
  else
  begin
    if (tx_push)
      tx_wr_q <= tx_wr_q + 6'h01;
    if (tx_pop)
      tx_rd_q <= tx_rd_q + 6'h01;
    if (tx_push & ~tx_pop)
      tx_cnt_q <= tx_cnt_q + 7'h01;
    else if (tx_pop & ~tx_push)
      tx_cnt_q <= tx_cnt_q - 7'h01;
  end
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    tst_q <= T_IDLE;
    tsh_q <= 8'h00;
    tpar_q <= 1'b0;
    tbit_q <= 3'h0;
    ttk_q <= 5'h00;
    tx_q <= 1'b1;
  end
  else
  begin
    case (tst_q)
      T_IDLE:
        if (tx_pop)
        begin
          tsh_q <= tx_mem[tx_rd_q];
          tpar_q <= par_bit(tx_mem[tx_rd_q], format_q);
          ttk_q <= 5'h00;
          tst_q <= T_START;
        end
      T_START, T_DATA, T_PAR:
        if (tick_q)
        begin
          ttk_q <= ttk_q + 5'h01;
          if (ttk_q == `TK_BIT)
          begin
            ttk_q <= 5'h00;
            if (tst_q == T_START)
            begin
              tbit_q <= 3'h0;
              tst_q <= T_DATA;
            end
            else if (tst_q == T_DATA)
            begin
              tsh_q <= {1'b0, tsh_q[7:1]};
              tbit_q <= tbit_q + 3'h1;
              if (tbit_q == {1'b1, format_q[1:0]})
                tst_q <= format_q[`LF_PEN] ? T_PAR : T_STOP;
            end
            else
              tst_q <= T_STOP;
          end
        end
      T_STOP:
        if (tick_q)
        begin
          ttk_q <= ttk_q + 5'h01;
          if (ttk_q == stop_end)
            tst_q <= T_IDLE;
        end
      default: tst_q <= T_IDLE;
    endcase
    if (format_q[`LF_BRK])
      tx_q <= 1'b0;
    else if (tst_q == T_START)
      tx_q <= 1'b0;
    else if (tst_q == T_DATA)
      tx_q <= tsh_q[0];
    else if (tst_q == T_PAR)
      tx_q <= tpar_q;
    else
      tx_q <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////
// Receive shifter
reg rx_push;
reg [10:0] rx_word;
wire [7:0] rx_byte = rsh_q >> (2'h3 - format_q[1:0]);

always @*
begin
  rx_push = (rst_q == R_STOP) & tick_q & (rtk_q == `TK_BIT);
  rx_word[7:0] = rx_byte;
  rx_word[10] = (rx_byte == 8'h00) & ~rx_s_q &
    ~(format_q[`LF_PEN] & rpar_q);
  rx_word[9] = ~rx_s_q;
  rx_word[8] = format_q[`LF_PEN] &
    (rpar_q != par_bit(rx_byte, format_q));
  if (rx_word[10])
    rx_word[7:0] = 8'h00;
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    rst_q <= R_IDLE;
    rsh_q <= 8'h00;
    rpar_q <= 1'b0;
    rbit_q <= 3'h0;
    rtk_q <= 5'h00;
  end
  else
  begin
    if (tick_q)
      rtk_q <= rtk_q + 5'h01;
    case (rst_q)
      R_IDLE:
        if (~rx_s_q)
        begin
          rtk_q <= 5'h00;
          rst_q <= R_START;
        end
      R_START:
        if (tick_q & (rtk_q == `TK_MID))
        begin
          rtk_q <= 5'h00;
          rbit_q <= 3'h0;
          rst_q <= rx_s_q ? R_IDLE : R_DATA;
        end
      R_DATA:
        if (tick_q & (rtk_q == `TK_BIT))
        begin
          rtk_q <= 5'h00;
          rsh_q <= {rx_s_q, rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == {1'b1, format_q[1:0]})
            rst_q <= format_q[`LF_PEN] ? R_PAR : R_STOP;
        end
      R_PAR:
        if (tick_q & (rtk_q == `TK_BIT))
        begin
          rtk_q <= 5'h00;
          rpar_q <= rx_s_q;
          rst_q <= R_STOP;
        end
      R_STOP:
        if (rx_push)
          rst_q <= rx_s_q ? R_IDLE : R_LOW;
      R_LOW:
        if (rx_s_q)
          rst_q <= R_IDLE;
      default: rst_q <= R_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Receive FIFO, error count, overrun
wire rx_full = fifo_en_q ? (rx_cnt_q == `FIFO_FULL) : rx_any;
wire rx_pop = rd_data & rx_any;
wire rx_lost = rx_push & rx_full & ~rx_pop;
wire rx_err_in = |rx_word[10:8];
wire rx_err_out = |head[10:8];
wire rx_store = rx_push & (~fifo_en_q | ~rx_full | rx_pop);
wire [5:0] rx_wa = fifo_en_q ? rx_wr_q : 6'h00;

always @*
begin
  err_cnt_d = err_cnt_q;
  if (~fifo_en_q)
  begin
    if (rx_push)
      err_cnt_d = {6'h00, rx_err_in};
    else if (rx_pop)
      err_cnt_d = 7'h00;
  end
  else
  begin
    if (rx_store & rx_err_in)
      err_cnt_d = err_cnt_d + 7'h01;
    if (rx_pop & rx_err_out)
      err_cnt_d = err_cnt_d - 7'h01;
  end
end

always @(posedge i_core_clk)
begin
  if (rx_store)
    rx_mem[rx_wa] <= rx_word;
end

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    rx_wr_q <= 6'h00;
    rx_rd_q <= 6'h00;
    rx_cnt_q <= 7'h00;
    err_cnt_q <= 7'h00;
    ovr_q <= 1'b0;
  end
  else
  begin
    if (rx_lost)
      ovr_q <= 1'b1;
    else if (rd_cond)
      ovr_q <= 1'b0;
    if (rx_clr)
    begin
      rx_wr_q <= 6'h00;
      rx_rd_q <= 6'h00;
      rx_cnt_q <= 7'h00;
      err_cnt_q <= 7'h00;
    end
    else if (~fifo_en_q)
    begin
      rx_wr_q <= 6'h00;
      rx_rd_q <= 6'h00;
      err_cnt_q <= err_cnt_d;
      if (rx_push)
        rx_cnt_q <= 7'h01;
      else if (rx_pop)
        rx_cnt_q <= 7'h00;
    end
    else
    begin
      err_cnt_q <= err_cnt_d;
      if (rx_store)
        rx_wr_q <= rx_wr_q + 6'h01;
      if (rx_pop)
        rx_rd_q <= rx_rd_q + 6'h01;
      if (rx_store & ~rx_pop)
        rx_cnt_q <= rx_cnt_q + 7'h01;
      else if (rx_pop & ~rx_store)
        rx_cnt_q <= rx_cnt_q - 7'h01;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// DMA request levels
reg [6:0] tx_lvl;
reg [6:0] rx_lvl;

always @*
begin
  case (tx_trig_q)
    2'h0: tx_lvl = `TT0;
    2'h1: tx_lvl = `TT1;
    2'h2: tx_lvl = `TT2;
    default: tx_lvl = `TT3;
  endcase
  case (rx_trig_q)
    2'h0: rx_lvl = `RT0;
    2'h1: rx_lvl = `RT1;
    2'h2: rx_lvl = `RT2;
    default: rx_lvl = `RT3;
  endcase
end

wire mode1 = dma_mode_q & fifo_en_q;

always @(posedge i_core_clk or negedge i_rst_n)
begin
  if (!i_rst_n)
  begin
    rx_req_n_q <= 1'b1;
    tx_req_n_q <= 1'b1;
  end
  else
  begin
    rx_req_n_q <= ~(mode1 ? (rx_cnt_q >= rx_lvl) : rx_any);
    tx_req_n_q <= ~(mode1 ? ((`FIFO_FULL - tx_cnt_q) >= tx_lvl) :
      tx_empty);
  end
end

assign o_prdata = prdata_q;
assign o_pready = pready_q;
assign o_pslverr = pslverr_q;
assign o_tx = tx_q;
assign o_rx_dma_req_n = rx_req_n_q;
assign o_tx_dma_req_n = tx_req_n_q;

endmodule

// File: tb/uart_fifo_line_control_sva.sv
// Port assertions for the UART FIFO and line control block
`timescale 1ns/1ps
module uart_fifo_line_control_sva (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [4:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_tx
);
  logic brk_q;
  wire setup = i_psel && !i_penable;
  wire bad = (i_paddr[1:0] != 2'h0) || (i_paddr[4:2] == 3'h4) ||
    (i_paddr[4:2] > 3'h5);
  wire fmt_wr = i_psel && i_penable && o_pready && i_pwrite &&
    (i_paddr == 5'h0c);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Break bit as last written to the format register
  always @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      brk_q <= 1'b0;
    else if (fmt_wr)
      brk_q <= i_pwdata[6];

  ////////////////////////////////////////////////////////////////////////
  a_ready_zero_wait: assert property (setup |=> o_pready)
    else $error("pready missing in access cycle");
  a_ready_one_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (setup && bad |=>
    o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && !bad |=> !o_pslverr)
    else $error("mapped access refused");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_read_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_break_low: assert property (brk_q && $past(brk_q) |-> !o_tx)
    else $error("tx not held low during break");
  a_start_bit_len: assert property ($fell(o_tx) && !brk_q |=>
    !o_tx [*8])
    else $error("start bit too short");

  c_write: cover property (fmt_wr);
  c_read: cover property (o_pready && !i_pwrite && !o_pslverr);
  c_break: cover property (brk_q && !o_tx);
endmodule

// File: tb/uart_line_partner.sv
// Remote serial station on the TX and RX lines, 16 clocks per bit
`timescale 1ns/1ps
module uart_line_partner (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;

  // Low start bit, then n frame bits, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    begin
      o_line <= 1'b0;
      repeat (16) @(posedge i_clk);
      for (int i = 0; i < n; i++)
      begin
        o_line <= bits[i];
        repeat (16) @(posedge i_clk);
      end
      o_line <= 1'b1;
      @(posedge i_clk);
    end
  endtask

  // Wait for a start bit, then sample n bits at their middles
  task automatic recv(input int n, output logic [11:0] f, output int w);
    begin
      w = 0;
      f = 12'h000;
      while (i_line !== 1'b0)
      begin
        w++;
        @(posedge i_clk);
      end
      repeat (8) @(posedge i_clk);
      for (int i = 0; i < n; i++)
      begin
        repeat (16) @(posedge i_clk);
        f[i] = i_line;
      end
    end
  endtask
endmodule

// File: tb/uart_fifo_line_control_bench.sv
// Self-checking bench for the UART FIFO and line control block
`timescale 1ns/1ps
module uart_fifo_line_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire rx;
  wire tx;
  wire rxq;
  wire txq;
  logic serr;
  logic [31:0] r;
  logic [11:0] f;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] fmt;
  int err_count = 0;
  int n_tests = 0;
  int g;
  int n;
  logic [7:0] fmts [5] = '{8'h04, 8'h1b, 8'h0d, 8'h2a, 8'h3b};
  logic [4:0] bad [4] = '{5'h10, 5'h18, 5'h1c, 5'h01};

  uart_fifo_line_control dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rx(rx), .o_tx(tx),
    .o_rx_dma_req_n(rxq), .o_tx_dma_req_n(txq));
  uart_line_partner line (.i_clk(clk), .i_line(tx), .o_line(rx));

  initial
    forever #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    begin
      n_tests++;
      if (got !== exp)
      begin
        err_count++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic apb(input logic [4:0] a, input logic w,
    input logic [7:0] v);
    begin
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, v};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    apb(a, 1'b1, v);
  endtask

  task automatic rd(input logic [4:0] a);
    apb(a, 1'b0, 8'h00);
  endtask

  function automatic logic [11:0] frame(input logic [7:0] m,
    input logic [7:0] v);
    int nb;
    logic p;
    begin
      nb = 5 + int'(m[1:0]);
      frame = 12'hfff;
      for (int i = 0; i < nb; i++)
        frame[i] = v[i];
      p = ^(v & (8'hff >> (8 - nb))) ^ !m[4];
      if (m[5])
        p = !m[4];
      if (m[3])
        frame[nb] = p;
    end
  endfunction

  function automatic int nbits(input logic [7:0] m);
    return 6 + int'(m[1:0]) + int'(m[3]);
  endfunction

  function automatic int stop_ticks(input logic [7:0] m);
    if (!m[2])
      return 16;
    return (m[1:0] == 2'b00) ? 24 : 32;
  endfunction

  // Receive one character, then check status, data and emptied status
  task automatic rx_case(input logic [11:0] fr, input logic [7:0] st,
    input logic [7:0] v);
    begin
      line.send(fr, nbits(fmt));
      chk("rx request", 32'h0, 32'(rxq));
      rd(5'h14);
      chk("status", {24'h0, st}, r);
      // Overrun clears on the first status read
      rd(5'h14);
      chk("status reread", {24'h0, st & 8'hfd}, r);
      rd(5'h00);
      chk("receive data", {24'h0, v}, r);
      rd(5'h14);
      chk("status after read", 32'h60, r);
    end
  endtask

  task automatic end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h9e9c9b32));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(5'h0c);
    chk("format reset", 32'h03, r);
    rd(5'h14);
    chk("status reset", 32'h60, r);
    foreach (bad[k])
    begin
      rd(bad[k]);
      chk("unmapped read", 32'h0, r);
      chk("slave error", 32'h1, 32'(serr));
    end
    rd(5'h04);
    chk("divisor closed", 32'h0, r);
    wr(5'h0c, 8'h83);
    wr(5'h04, 8'h5a);
    rd(5'h04);
    chk("divisor high", 32'h5a, r);
    wr(5'h04, 8'h00);
    foreach (fmts[k])
    begin
      fmt = fmts[k];
      d = 8'($urandom());
      d2 = 8'($urandom());
      wr(5'h0c, fmt);
      n = nbits(fmt);
      fork
        line.recv(n, f, g);
        begin
          wr(5'h00, d);
          wr(5'h00, d2);
        end
      join
      chk("frame", 32'(frame(fmt, d) & ~(12'hfff << n)), 32'(f));
      line.recv(n, f, g);
      chk("frame", 32'(frame(fmt, d2) & ~(12'hfff << n)), 32'(f));
      // One idle clock follows the stop bits before the next start
      chk("stop gap", 32'(stop_ticks(fmt) - 7), 32'(g));
    end
    repeat (400) @(posedge clk);
    wr(5'h0c, 8'h43);
    repeat (4) @(posedge clk);
    chk("tx in break", 32'h0, 32'(tx));
    wr(5'h0c, 8'h03);
    repeat (2) @(posedge clk);
    chk("tx after break", 32'h1, 32'(tx));
    wr(5'h00, d);
    wr(5'h00, d2);
    wr(5'h00, d);
    wr(5'h08, 8'h04);
    rd(5'h14);
    chk("status tx cleared", 32'h20, r);
    repeat (300) @(posedge clk);
    rd(5'h14);
    chk("status tx done", 32'h60, r);
    chk("tx request", 32'h0, 32'(txq));
    fmt = 8'h1b;
    wr(5'h0c, fmt);
    rx_case(frame(fmt, d), 8'h61, d);
    rx_case(frame(fmt, d2) ^ 12'h100, 8'he5, d2);
    line.send(frame(fmt, d), 10);
    rx_case(frame(fmt, d2), 8'h63, d2);
    fmt = 8'h03;
    wr(5'h0c, fmt);
    // Nonzero byte, so a missing stop reads as framing, not break
    rx_case(frame(fmt, d | 8'h01) & 12'h0ff, 8'he9, d | 8'h01);
    rx_case(12'h000, 8'hf9, 8'h00);
    wr(5'h08, 8'h01);
    line.send(frame(fmt, d), 9);
    line.send(frame(fmt, d2), 9);
    line.send(frame(fmt, d), 9);
    rd(5'h14);
    chk("status fifo on", 32'h61, r);
    rd(5'h00);
    chk("fifo order", {24'h0, d}, r);
    rd(5'h00);
    chk("fifo order", {24'h0, d2}, r);
    wr(5'h08, 8'h03);
    rd(5'h14);
    chk("status rx cleared", 32'h60, r);
    // DMA mode 1; transmit trigger field refused until enhanced on
    wr(5'h08, 8'h39);
    repeat (20) wr(5'h00, d);
    @(posedge clk);
    chk("tx request", 32'h0, 32'(txq));
    wr(5'h0c, 8'hbf);
    wr(5'h08, 8'h10);
    wr(5'h0c, fmt);
    wr(5'h08, 8'h39);
    @(posedge clk);
    chk("tx request", 32'h1, 32'(txq));
    line.send(frame(fmt, d), 9);
    chk("rx request", 32'h1, 32'(rxq));
    end_of_test();
  end
endmodule

bind uart_fifo_line_control uart_fifo_line_control_sva chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_tx(o_tx));
